// ### cfg_bank_pkg.sv
// Package with register map, field layout, reset values and pattern codes.
package cfg_bank_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SAMPLE_W = 14;

  // ***********************************************
  // Register offsets.
  // ***********************************************
  localparam logic [7:0] OFS_TIMING = 8'h62;
  localparam logic [7:0] OFS_FORMAT = 8'h63;
  localparam logic [7:0] OFS_PATTERN = 8'h65;
  localparam logic [7:0] OFS_GAIN = 8'h68;
  localparam logic [7:0] OFS_WORD_LO = 8'h69;
  localparam logic [7:0] OFS_WORD_HI = 8'h6a;
  localparam logic [7:0] OFS_CLKBUF = 8'h6b;
  localparam logic [7:0] OFS_IFACE = 8'h6c;
  localparam logic [7:0] OFS_STATUS = 8'h70;

  // ***********************************************
  // Field positions.
  // ***********************************************
  localparam int CLKPOS_LSB = 0;
  localparam int CLKPOS_MSB = 4;
  localparam int DATAPOS_LSB = 5;
  localparam int DATAPOS_MSB = 6;
  localparam int CODING_BIT = 3;
  localparam int LOWRATE_BIT = 4;
  localparam int PWRDN_BIT = 7;
  localparam int PAT_LSB = 5;
  localparam int PAT_MSB = 7;
  localparam int GAIN_MSB = 3;
  localparam int CLKBUF_MSB = 5;
  localparam int WORD_HI_MSB = 5;
  localparam int IFACE_LSB = 3;
  localparam int IFACE_MSB = 4;
  localparam int SWRST_BIT = 1;

  // ***********************************************
  // Reset values and codes.
  // ***********************************************
  localparam logic [7:0] RST_TIMING = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_GAIN = 8'h08;
  localparam logic [7:0] RST_CLKBUF = 8'h20;
  localparam logic [1:0] IFACE_CMOS = 2'h3;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 14'h0000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ONES = 14'h3fff;
  localparam logic [SAMPLE_W-1:0] SAMPLE_TOGGLE = 14'h1555;
  localparam logic [SAMPLE_W-1:0] SAMPLE_MSB = 14'h2000;
  localparam logic [SAMPLE_W-1:0] RAMP_STEP = 14'h0001;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    PAT_NORMAL = 3'h0,
    PAT_ZEROS = 3'h1,
    PAT_ONES = 3'h2,
    PAT_TOGGLE = 3'h3,
    PAT_RAMP = 3'h4,
    PAT_CUSTOM = 3'h5
  } pattern_e;

  // Clock edge shift codes for the output clock stage.
  typedef enum logic [1:0] {
    SHIFT_DEFAULT = 2'h0,
    SHIFT_ONE = 2'h1,
    SHIFT_THREE = 2'h2,
    SHIFT_TWO = 2'h3
  } clk_shift_e;

endpackage

// ### sample_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  // Clock and control.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Fill side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = ce_i && in_valid_i && in_ready_o;
  wire pop = ce_i && out_valid_o && out_ready_i;

  assign in_ready_o = count_reg != (AW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o = mem[rd_ptr_reg];

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### cfg_bank.sv
// Converter configuration register bank with test pattern output path.
//
// Contract
// RQ1 - Clock phase code resets to 00001.
// RQ2 - Codes XX011/01XX1 shift clock one twelfth.
// RQ3 - Codes XX101/10XX1 shift three twelfths, LVDS aligned.
// RQ4 - Codes XX111/11XX1 shift two twelfths, LVDS aligned.
// RQ5 - Data position only in CMOS; resets 00.
// RQ6 - Data position codes adjust setup time.
// RQ7 - Bit 3 selects twos complement or offset.
// RQ8 - Bit 4 selects low speed mode.
// RQ9 - Bit 7 powers down core and outputs.
// RQ10 - Pattern 000 normal, 001 zeros, 010 ones.
// RQ11 - Pattern 011 toggles across bits and time.
// RQ12 - Pattern 100 ramps upward each sample.
// RQ13 - Pattern 101 drives custom word; 111 unused.
// RQ14 - Custom word from registers 69 and 6A.
// RQ15 - Gain resets to 0 dB code.
// RQ16 - Clock buffer gain resets to 100000.
// RQ17 - Host writes zero to unused bits.
// RQ18 - Software reset restores all defaults.
// RQ19 - Ramp wraps to zero after full scale.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module cfg_bank
  import cfg_bank_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [cfg_bank_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cfg_bank_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [cfg_bank_pkg::DATA_W-1:0] rdata_o,
  // Converter sample input.
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [cfg_bank_pkg::SAMPLE_W-1:0] sample_i,
  // Output data stream.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [cfg_bank_pkg::SAMPLE_W-1:0] out_data_o,
  // Analog and timing controls.
  output logic [1:0] clk_shift_o,
  output logic clk_early_o,
  output logic clk_aligned_o,
  output logic [1:0] data_pos_o,
  output logic cmos_mode_o,
  output logic low_rate_o,
  output logic power_down_o,
  output logic [3:0] gain_o,
  output logic [5:0] clkbuf_gain_o
);
  import cfg_bank_pkg::*;

  // ***********************************************
  // Register storage.
  // ***********************************************
  logic [7:0] timing_reg;
  logic [7:0] format_reg;
  logic [7:0] pattern_reg;
  logic [7:0] gain_reg;
  logic [7:0] word_lo_reg;
  logic [7:0] word_hi_reg;
  logic [7:0] clkbuf_reg;
  logic [7:0] iface_reg;
  logic [SAMPLE_W-1:0] ramp_reg;
  logic [7:0] rdata_reg;
  logic [SAMPLE_W-1:0] data_reg;
  logic data_valid_reg;

  // ***********************************************
  // Decode.
  // ***********************************************
  wire wr_en = ce_i && wr_i;
  wire sw_reset = wr_en && addr_i == OFS_IFACE && wdata_i[SWRST_BIT];
  wire [4:0] clk_code = timing_reg[CLKPOS_MSB:CLKPOS_LSB];
  wire [2:0] pat_code = pattern_reg[PAT_MSB:PAT_LSB];
  wire [SAMPLE_W-1:0] custom_word = {word_hi_reg[WORD_HI_MSB:0], word_lo_reg}; // [RQ14]
  wire fifo_in_ready;
  wire hold_stage = data_valid_reg && !fifo_in_ready;
  wire pat_write = wr_en && addr_i == OFS_PATTERN;

  // Maps a five-bit phase code to a clock edge shift.
  function automatic clk_shift_e decode_shift(input logic [4:0] code);
    if (code[2:0] == 3'b011 || (code[4:3] == 2'b01 && code[0])) begin
      decode_shift = SHIFT_ONE; // [RQ2]
    end else if (code[2:0] == 3'b101 || (code[4:3] == 2'b10 && code[0])) begin
      decode_shift = SHIFT_THREE; // [RQ3]
    end else if (code[2:0] == 3'b111 || (code[4:3] == 2'b11 && code[0])) begin
      decode_shift = SHIFT_TWO; // [RQ4]
    end else begin
      decode_shift = SHIFT_DEFAULT;
    end
  endfunction

  wire clk_shift_e shift_sel = decode_shift(clk_code);
  assign clk_shift_o = shift_sel;
  assign cmos_mode_o = iface_reg[IFACE_MSB:IFACE_LSB] == IFACE_CMOS;
  assign clk_early_o = !cmos_mode_o && shift_sel == SHIFT_ONE; // [RQ2]
  assign clk_aligned_o = !cmos_mode_o
    && (shift_sel == SHIFT_THREE || shift_sel == SHIFT_TWO); // [RQ3] [RQ4]
  assign data_pos_o = cmos_mode_o ? timing_reg[DATAPOS_MSB:DATAPOS_LSB] : 2'b00; // [RQ5] [RQ6]
  assign low_rate_o = format_reg[LOWRATE_BIT]; // [RQ8]
  assign power_down_o = format_reg[PWRDN_BIT]; // [RQ9]
  assign gain_o = gain_reg[GAIN_MSB:0];
  assign clkbuf_gain_o = clkbuf_reg[CLKBUF_MSB:0];
  assign rdata_o = rdata_reg;

  // Sample coding: offset binary flips the sign bit of the converter's twos complement word.
  wire [SAMPLE_W-1:0] coded_sample = format_reg[CODING_BIT] ? (sample_i ^ SAMPLE_MSB)
                                                           : sample_i; // [RQ7]
  logic [SAMPLE_W-1:0] pattern_data;
  always_comb begin
    unique case (pat_code)
      PAT_ZEROS: pattern_data = SAMPLE_ZERO; // [RQ10]
      PAT_ONES: pattern_data = SAMPLE_ONES; // [RQ10]
      PAT_TOGGLE: pattern_data = ramp_reg[0] ? ~SAMPLE_TOGGLE : SAMPLE_TOGGLE; // [RQ11]
      PAT_RAMP: pattern_data = ramp_reg; // [RQ12]
      PAT_CUSTOM: pattern_data = custom_word; // [RQ13]
      default: pattern_data = coded_sample; // [RQ10] [RQ13]
    endcase
  end

  // Pattern modes generate their own stream, so the input is drained while they run.
  wire normal_mode = pat_code == PAT_NORMAL;
  wire stage_take = !hold_stage && !power_down_o && (normal_mode ? sample_valid_i : 1'b1);
  assign sample_ready_o = !hold_stage && !power_down_o;

  // ***********************************************
  // Register writes.
  // ***********************************************
  always_ff @(posedge clock_i) begin
    if (rst_i || sw_reset) begin // [RQ18]
      timing_reg <= RST_TIMING; // [RQ1] [RQ5]
      format_reg <= RST_ZERO;
      pattern_reg <= RST_ZERO;
      gain_reg <= RST_GAIN; // [RQ15]
      word_lo_reg <= RST_ZERO;
      word_hi_reg <= RST_ZERO;
      clkbuf_reg <= RST_CLKBUF; // [RQ16]
      iface_reg <= RST_ZERO;
    end else if (wr_en) begin
      unique case (addr_i)
        OFS_TIMING: timing_reg <= wdata_i;
        OFS_FORMAT: format_reg <= wdata_i;
        OFS_PATTERN: pattern_reg <= wdata_i;
        OFS_GAIN: gain_reg <= wdata_i;
        OFS_WORD_LO: word_lo_reg <= wdata_i;
        OFS_WORD_HI: word_hi_reg <= wdata_i;
        OFS_CLKBUF: clkbuf_reg <= wdata_i;
        OFS_IFACE: iface_reg <= wdata_i;
        default: ;
      endcase
    end
  end

  // ***********************************************
  // Readback.
  // ***********************************************
  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr_i)
      OFS_TIMING: rd_mux = timing_reg;
      OFS_FORMAT: rd_mux = format_reg;
      OFS_PATTERN: rd_mux = pattern_reg;
      OFS_GAIN: rd_mux = gain_reg;
      OFS_WORD_LO: rd_mux = word_lo_reg;
      OFS_WORD_HI: rd_mux = word_hi_reg;
      OFS_CLKBUF: rd_mux = clkbuf_reg;
      OFS_IFACE: rd_mux = iface_reg;
      OFS_STATUS: rd_mux = {5'h00, fifo_in_ready, out_valid_o, data_valid_reg};
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_reg <= RST_ZERO;
    end else if (ce_i) begin
      rdata_reg <= rd_i ? rd_mux : RST_ZERO;
    end
  end

  // ***********************************************
  // Pattern generator and output stage.
  // ***********************************************
  always_ff @(posedge clock_i) begin
    // Any pattern write restarts the counter, so a newly chosen ramp begins at zero.
    if (rst_i || sw_reset || pat_write
        || (ce_i && pat_code != PAT_RAMP && pat_code != PAT_TOGGLE)) begin // [RQ12]
      ramp_reg <= SAMPLE_ZERO;
    end else if (ce_i && stage_take) begin
      ramp_reg <= ramp_reg + RAMP_STEP; // [RQ12] [RQ19]
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_reg <= SAMPLE_ZERO;
      data_valid_reg <= 1'b0;
    end else if (ce_i) begin
      if (stage_take) begin
        data_reg <= pattern_data;
        data_valid_reg <= 1'b1;
      end else if (!hold_stage) begin
        data_valid_reg <= 1'b0;
      end
    end
  end

  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(data_valid_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(data_reg),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o(out_data_o)
  );
endmodule

// ### cfg_bank_properties.sv
// Checker for the configuration bank control outputs.
`timescale 1ns/1ns
module cfg_bank_properties
  import cfg_bank_pkg::*;
(
  // Clock and register port.
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  // Controls.
  input wire logic [1:0] clk_shift_o,
  input wire logic clk_early_o,
  input wire logic clk_aligned_o,
  input wire logic [1:0] data_pos_o,
  input wire logic cmos_mode_o,
  input wire logic low_rate_o,
  input wire logic power_down_o,
  input wire logic [3:0] gain_o,
  input wire logic [5:0] clkbuf_gain_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_wr(a);
    ce_i && wr_i && addr_i == a;
  endsequence
  a_reset_defaults: assert property ($fell(rst_i) |-> clk_shift_o == 2'h0 &&
    gain_o == 4'h8 && clkbuf_gain_o == 6'h20 && data_pos_o == 2'h0) else $error("bad reset");
  a_soft_reset: assert property (s_wr(OFS_IFACE) ##0 wdata_i[1] |=> gain_o == 4'h8 &&
    clkbuf_gain_o == 6'h20 && clk_shift_o == 2'h0 && !power_down_o) else $error("soft reset");
  a_gain_write: assert property (s_wr(OFS_GAIN) |=> gain_o == $past(wdata_i[3:0]))
    else $error("gain field");
  a_clkbuf_write: assert property (s_wr(OFS_CLKBUF) |=>
    clkbuf_gain_o == $past(wdata_i[5:0])) else $error("clock buffer gain");
  a_mode_bits: assert property (s_wr(OFS_FORMAT) |=>
    power_down_o == $past(wdata_i[7]) && low_rate_o == $past(wdata_i[4]))
    else $error("mode bits");
  a_phase_decode: assert property (s_wr(OFS_TIMING) ##0 (wdata_i[0] &&
    (wdata_i[4:3] == 2'h0 || wdata_i[2:1] == 2'h0)) |=>
    clk_shift_o == $past(wdata_i[4:3] | wdata_i[2:1])) else $error("phase decode");
  a_early_edge: assert property (clk_early_o == (!cmos_mode_o && clk_shift_o == 2'h1))
    else $error("early edge");
  a_aligned_edge: assert property (
    clk_aligned_o == (!cmos_mode_o && clk_shift_o[1])) else $error("aligned edge");
  a_pos_lvds: assert property (!cmos_mode_o |-> data_pos_o == 2'h0)
    else $error("data position in lvds");
  a_pos_cmos: assert property (s_wr(OFS_TIMING) ##1 cmos_mode_o |->
    data_pos_o == $past(wdata_i[6:5])) else $error("data position");
endmodule
bind cfg_bank cfg_bank_properties cfg_bank_properties_i (.clock_i, .rst_i, .ce_i, .addr_i,
  .wdata_i, .wr_i, .clk_shift_o, .clk_early_o, .clk_aligned_o, .data_pos_o, .cmos_mode_o,
  .low_rate_o, .power_down_o, .gain_o, .clkbuf_gain_o);

// ### stream_partner.sv
// Converter source and downstream sink around the sample stream.
`timescale 1ns/1ns
module stream_partner (
  // Clock and stall control.
  input wire logic clock_i,
  input wire logic stall_i,
  // Streams.
  output logic sample_valid_o = 1'b0,
  output logic [13:0] sample_o = 14'h0000,
  output logic out_ready_o = 1'b0
);
  always_ff @(posedge clock_i) begin
    sample_valid_o <= 1'b1;
    sample_o <= 14'h0123;
    out_ready_o <= !stall_i;
  end
endmodule

// ### testbench.sv
// Self-checking bench for the configuration bank.
`timescale 1ns/1ns
module testbench;
  import cfg_bank_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stall = 1'b0;
  logic ce = 1'b1;
  logic [7:0] rdata_o;
  logic sample_valid_i, sample_ready_o, out_valid_o, out_ready_i;
  logic clk_early_o, clk_aligned_o, cmos_mode_o, low_rate_o, power_down_o;
  logic [13:0] sample_i, out_data_o, prev;
  logic [1:0] clk_shift_o, data_pos_o;
  logic [3:0] gain_o;
  logic [5:0] clkbuf_gain_o;
  logic [7:0] ra [8] = '{8'h62, 8'h63, 8'h65, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h64};
  logic [7:0] rv [8] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h20, 8'h00};
  logic [7:0] pc [6] = '{8'h03, 8'h05, 8'h07, 8'h09, 8'h11, 8'h19};
  logic [1:0] ps [6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
  logic [13:0] pv [6] = '{14'h0123, 14'h0000, 14'h3fff, 14'h0000, 14'h0000, 14'h1234};
  int n_mismatch = 0;
  int checks_done = 0;
  always #5 clock_i = ~clock_i;
  stream_partner stream_partner_i (.clock_i, .stall_i(stall), .sample_valid_o(sample_valid_i),
    .sample_o(sample_i), .out_ready_o(out_ready_i));
  cfg_bank cfg_bank_i (.clock_i, .rst_i, .ce_i(ce), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .sample_valid_i, .sample_ready_o, .sample_i, .out_valid_o, .out_ready_i, .out_data_o,
    .clk_shift_o, .clk_early_o, .clk_aligned_o, .data_pos_o, .cmos_mode_o, .low_rate_o,
    .power_down_o, .gain_o, .clkbuf_gain_o);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
    @(posedge clock_i);
  endtask
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ***********************************************
  // Tests.
  // ***********************************************
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int i = 0; i < 8; i++)
      rd(ra[i], rv[i]);
    wr(OFS_GAIN, 8'h0e);
    wr(OFS_CLKBUF, 8'h32);
    rd(OFS_GAIN, 8'h0e);
    chk(clkbuf_gain_o, 16'h0032);
    ce <= 1'b0;
    wr(OFS_GAIN, 8'h09);
    ce <= 1'b1;
    chk(gain_o, 16'h000e);
    wr(OFS_IFACE, 8'h02);
    chk(gain_o, 16'h0008);
    $display("register test done");
    for (int i = 0; i < 6; i++) begin
      wr(OFS_TIMING, pc[i]);
      chk({clk_shift_o, clk_early_o, clk_aligned_o}, {ps[i], ps[i] == 2'h1, ps[i][1]});
    end
    wr(OFS_IFACE, 8'h18);
    chk(cmos_mode_o, 16'h0001);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_TIMING, {1'b0, 2'(p), 5'h07});
      chk({data_pos_o, clk_early_o, clk_aligned_o}, {2'(p), 2'h0});
    end
    wr(OFS_IFACE, 8'h00);
    chk(data_pos_o, 16'h0000);
    $display("timing test done");
    wr(OFS_WORD_LO, 8'h34);
    wr(OFS_WORD_HI, 8'h12);
    foreach (pv[c]) begin
      wr(OFS_PATTERN, {3'(c), 5'h00});
      repeat (8) step();
      if (c < 3 || c == 5)
        chk(out_data_o, pv[c]);
    end
    wr(OFS_FORMAT, 8'h08);
    wr(OFS_PATTERN, 8'h00);
    repeat (8) step();
    chk(out_data_o, 16'h2123);
    wr(OFS_PATTERN, 8'he0);
    repeat (8) step();
    chk(out_data_o, 16'h2123);
    wr(OFS_PATTERN, 8'h60);
    repeat (8) step();
    prev = out_data_o;
    chk(prev == 14'h1555 || prev == 14'h2aaa, 16'h0001);
    step();
    chk(out_data_o, 14'(~prev));
    wr(OFS_PATTERN, 8'h80);
    step();
    chk(out_data_o, 16'h0000);
    repeat (8) step();
    prev = out_data_o;
    step();
    chk(out_data_o, 14'(prev + 14'h0001));
    for (int i = 0; i < 17000 && out_data_o !== 14'h3fff; i++)
      step();
    step();
    chk(out_data_o, 16'h0000);
    $display("pattern test done");
    stall <= 1'b1;
    wr(OFS_PATTERN, 8'h00);
    repeat (40) step();
    chk({sample_ready_o, out_valid_o}, 16'h0001);
    rd(OFS_STATUS, 8'h03);
    wr(OFS_FORMAT, 8'h80);
    chk(power_down_o, 16'h0001);
    stall <= 1'b0;
    repeat (40) step();
    chk(out_valid_o, 16'h0000);
    wr(OFS_FORMAT, 8'h10);
    chk({low_rate_o, power_down_o}, 16'h0002);
    $display("buffer test done");
    stop_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    stop_test();
  end
endmodule
